//--- rtl/mcu_interrupt_sources.sv
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module mcu_interrupt_sources
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// external pins
	input wire logic [1:0] ext_irq_pin,
	output logic [1:0] pin_pullup_en,
	// peripheral events
	input wire logic [1:0] cmp_out,
	input wire logic [15:0] mf_src_req,
	input wire logic conv_done,
	input wire logic timebase_src_clock,
	// cpu sequencer
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [3:0] irq_vector
);
	localparam int N = irq_src_pkg::NUM_SRC;
	localparam int TW = irq_src_pkg::TB_CNT_W;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic gie;
		logic [1:0] ext_irq_enable;
		logic [1:0] cmp_en;
		logic [3:0] mf_en;
		logic conv_irq_enable;
		logic [1:0] tb_en;
		logic [1:0] pull;
		logic [3:0] edge_select_reg;
		logic [N-1:0] flags;
		logic [15:0] src_flag;
		logic [15:0] src_en;
		logic [7:0] timebase_ctrl_reg;
		logic armed;
		logic [1:0] pin_q;
		logic [1:0] cmp_q;
		logic [TW-1:0] tb_cnt;
		logic [1:0] div4;
		logic req;
		logic [3:0] vec;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	logic [1:0] ext_hit;
	logic [1:0] cmp_hit;
	logic [3:0] mf_hit;
	logic tb_tick;
	logic [1:0] tb_ovf;
	logic [N-1:0] set_vec;
	logic [N-1:0] clr_vec;
	logic [N-1:0] pending;
	logic addr_phase;
	logic [TW-1:0] tb0_mask;
	logic [TW-1:0] tb1_mask;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;
	assign pin_pullup_en = st_ff.pull;
	assign irq_req = st_ff.req;
	assign irq_vector = st_ff.vec;
	assign addr_phase = hsel & htrans[1] & hready;

	// per pin edge detection and enable gating
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_pin
			logic rise;
			logic fall;
			logic [1:0] mode;
			assign rise = st_ff.armed & ext_irq_pin[gp] & ~st_ff.pin_q[gp];
			assign fall = st_ff.armed & ~ext_irq_pin[gp] & st_ff.pin_q[gp];
			assign mode = st_ff.edge_select_reg[2*gp +: 2];
			// pin is an interrupt input only while enabled
			assign ext_hit[gp] = st_ff.ext_irq_enable[gp] &
				(((mode == irq_src_pkg::EDGE_RISE) & rise) |
				((mode == irq_src_pkg::EDGE_FALL) & fall) |
				((mode == irq_src_pkg::EDGE_BOTH) & (rise | fall)));
			// any change of comparator output
			assign cmp_hit[gp] = st_ff.armed & (cmp_out[gp] ^ st_ff.cmp_q[gp]);
		end
	endgenerate

	// group flag on any enabled source request of the group
	genvar gm;
	generate
		for (gm = 0; gm < irq_src_pkg::MF_GROUPS; gm++)
		begin : g_mf
			assign mf_hit[gm] = |(mf_src_req[4*gm +: 4] & st_ff.src_en[4*gm +: 4]);
		end
	endgenerate

	// time base: source tick or system clock divided by four
	assign tb_tick = st_ff.timebase_ctrl_reg[irq_src_pkg::TBC_ON] &
		(st_ff.timebase_ctrl_reg[irq_src_pkg::TBC_CK] ?
		(st_ff.div4 == 2'h3) : timebase_src_clock);
	assign tb0_mask = TW'((32'h1 << (irq_src_pkg::TB0_BASE_LOG2 +
		int'(st_ff.timebase_ctrl_reg[irq_src_pkg::TBC_TB0 +: 3]))) - 32'h1);
	assign tb1_mask = TW'((32'h1 << (irq_src_pkg::TB1_BASE_LOG2 +
		int'(st_ff.timebase_ctrl_reg[irq_src_pkg::TBC_TB1 +: 2]))) - 32'h1);
	assign tb_ovf[0] = tb_tick & ((st_ff.tb_cnt & tb0_mask) == tb0_mask);
	assign tb_ovf[1] = tb_tick & ((st_ff.tb_cnt & tb1_mask) == tb1_mask);

	// flags latch regardless of vector enables; pin flags need ext_irq_enable, group flags src_en
	assign set_vec = {tb_ovf, conv_done, mf_hit, cmp_hit, ext_hit};

	always_comb
	begin
		logic [N-1:0] wr_clr;
		logic [N-1:0] ack_clr;
		logic [31:0] rd;
		logic [31:0] ctrl;
		wr_clr = '0;
		ack_clr = '0;
		rd = '0;
		ctrl = '0;
		nxt_st = st_ff;
		nxt_st.armed = 1'b1;
		nxt_st.pin_q = ext_irq_pin;
		nxt_st.cmp_q = cmp_out;
		nxt_st.div4 = st_ff.div4 + 2'h1;
		if (tb_tick)
		begin
			nxt_st.tb_cnt = st_ff.tb_cnt + TW'(1);
		end
		// register writes in the data phase
		if (st_ff.wr_pend)
		begin
			case (st_ff.wr_addr)
				irq_src_pkg::OFS_CTRL:
				begin
					nxt_st.gie = hwdata[irq_src_pkg::CTRL_GIE];
					nxt_st.ext_irq_enable = hwdata[irq_src_pkg::CTRL_EXT_EN +: 2];
					nxt_st.cmp_en = hwdata[irq_src_pkg::CTRL_CMP_EN +: 2];
					nxt_st.mf_en = hwdata[irq_src_pkg::CTRL_MF_EN +: 4];
					nxt_st.conv_irq_enable = hwdata[irq_src_pkg::CTRL_CONV_EN];
					nxt_st.tb_en = hwdata[irq_src_pkg::CTRL_TB_EN +: 2];
					nxt_st.pull = hwdata[irq_src_pkg::CTRL_PULL +: 2];
				end
				irq_src_pkg::OFS_EDGE: nxt_st.edge_select_reg = hwdata[3:0];
				irq_src_pkg::OFS_FLAGS: wr_clr = hwdata[N-1:0];
				irq_src_pkg::OFS_SRC_EN: nxt_st.src_en = hwdata[15:0];
				irq_src_pkg::OFS_TBC: nxt_st.timebase_ctrl_reg = hwdata[7:0];
				default: ;
			endcase
		end
		// source flags: set wins over a write-one clear
		if (st_ff.wr_pend && st_ff.wr_addr == irq_src_pkg::OFS_SRC_FLAG)
		begin
			nxt_st.src_flag = st_ff.src_flag & ~hwdata[15:0];
		end
		// servicing never touches the grouped source flags
		nxt_st.src_flag = nxt_st.src_flag | mf_src_req;
		// service clears the vectored flag and the global enable
		if (irq_ack && st_ff.req)
		begin
			ack_clr[st_ff.vec] = 1'b1;
			nxt_st.gie = 1'b0;
		end
		// a new event in the clearing cycle is kept
		nxt_st.flags = (st_ff.flags & ~(wr_clr | ack_clr)) | set_vec;
		// enabled pending sources, blocked while the stack is full
		pending = nxt_st.flags & {nxt_st.tb_en, nxt_st.conv_irq_enable,
			nxt_st.mf_en, nxt_st.cmp_en, nxt_st.ext_irq_enable};
		nxt_st.req = nxt_st.gie & ~stack_full & (|pending);
		nxt_st.vec = st_ff.vec;
		// fixed priority, lowest index first, one at a time
		for (int i = N - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				nxt_st.vec = 4'(i);
			end
		end
		// address phase: latch write, or read from the updated state
		nxt_st.wr_pend = addr_phase & hwrite;
		nxt_st.wr_addr = haddr[7:0];
		ctrl[irq_src_pkg::CTRL_GIE] = nxt_st.gie;
		ctrl[irq_src_pkg::CTRL_EXT_EN +: 2] = nxt_st.ext_irq_enable;
		ctrl[irq_src_pkg::CTRL_CMP_EN +: 2] = nxt_st.cmp_en;
		ctrl[irq_src_pkg::CTRL_MF_EN +: 4] = nxt_st.mf_en;
		ctrl[irq_src_pkg::CTRL_CONV_EN] = nxt_st.conv_irq_enable;
		ctrl[irq_src_pkg::CTRL_TB_EN +: 2] = nxt_st.tb_en;
		ctrl[irq_src_pkg::CTRL_PULL +: 2] = nxt_st.pull;
		case (haddr[7:0])
			irq_src_pkg::OFS_CTRL: rd = ctrl;
			irq_src_pkg::OFS_EDGE: rd = {28'h0, nxt_st.edge_select_reg};
			irq_src_pkg::OFS_FLAGS: rd = 32'(nxt_st.flags);
			irq_src_pkg::OFS_SRC_FLAG: rd = {16'h0, nxt_st.src_flag};
			irq_src_pkg::OFS_SRC_EN: rd = {16'h0, nxt_st.src_en};
			irq_src_pkg::OFS_TBC: rd = {24'h0, nxt_st.timebase_ctrl_reg};
			irq_src_pkg::OFS_STATUS: rd = {26'h0, stack_full, nxt_st.req,
				nxt_st.vec};
			default: rd = 32'h0;
		endcase
		// unaligned or unmapped offsets read as zero
		if (haddr[31:8] != 24'h0 || haddr[1:0] != 2'h0)
		begin
			rd = 32'h0;
			nxt_st.wr_pend = 1'b0;
		end
		if (addr_phase && !hwrite)
		begin
			nxt_st.rdata = rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff <= '0;
			st_ff.timebase_ctrl_reg <= irq_src_pkg::TBC_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_req_needs_gie: assert property (irq_req |-> st_ff.gie)
		else $error("request raised without global enable");
	a_stack_full_block: assert property ($past(stack_full) |-> !irq_req)
		else $error("request raised while stack full");
	a_ack_drops_gie: assert property (irq_ack && irq_req |=> !st_ff.gie ##1 !irq_req)
		else $error("service did not clear global enable");
	a_conv_flag_clr: assert property (irq_ack && irq_req &&
		irq_vector == 4'(irq_src_pkg::ID_CONV) && !conv_done
		|=> !st_ff.flags[irq_src_pkg::ID_CONV])
		else $error("converter flag not cleared by service");
	a_ext_rise_set: assert property (st_ff.ext_irq_enable[0] &&
		st_ff.edge_select_reg[1:0] == irq_src_pkg::EDGE_RISE &&
		st_ff.armed && ext_irq_pin[0] && !st_ff.pin_q[0]
		|=> st_ff.flags[irq_src_pkg::ID_EXT0])
		else $error("rising edge did not set external flag");
	a_edge_off_quiet: assert property (st_ff.edge_select_reg[1:0] ==
		irq_src_pkg::EDGE_OFF && !st_ff.flags[irq_src_pkg::ID_EXT0]
		|=> !st_ff.flags[irq_src_pkg::ID_EXT0])
		else $error("disabled pin set its flag");
	a_cmp_change_set: assert property (st_ff.armed &&
		(cmp_out[0] != st_ff.cmp_q[0]) |=> st_ff.flags[irq_src_pkg::ID_CMP0])
		else $error("comparator change did not set flag");
	a_src_kept: assert property (irq_ack && !st_ff.wr_pend |=>
		(st_ff.src_flag & $past(st_ff.src_flag)) == $past(st_ff.src_flag))
		else $error("service changed grouped source flags");
	a_prio_lowest: assert property (irq_req && st_ff.flags[0] &&
		st_ff.ext_irq_enable[0] |-> irq_vector == 4'h0)
		else $error("priority order violated");
	a_mf_group_set: assert property (mf_hit[0] |=>
		st_ff.flags[irq_src_pkg::ID_MF0])
		else $error("group flag not set by source");

	// enables in source order, for the vector checks below
	logic [N-1:0] en_vec;
	assign en_vec = {st_ff.tb_en, st_ff.conv_irq_enable, st_ff.mf_en,
		st_ff.cmp_en, st_ff.ext_irq_enable};

	a_ext_fall_set: assert property (st_ff.ext_irq_enable[0] &&
		st_ff.edge_select_reg[1:0] == irq_src_pkg::EDGE_FALL &&
		st_ff.armed && !ext_irq_pin[0] && st_ff.pin_q[0]
		|=> st_ff.flags[irq_src_pkg::ID_EXT0])
		else $error("falling edge did not set external flag");
	a_ext_both_set: assert property (st_ff.ext_irq_enable[0] &&
		st_ff.edge_select_reg[1:0] == irq_src_pkg::EDGE_BOTH &&
		st_ff.armed && (ext_irq_pin[0] != st_ff.pin_q[0])
		|=> st_ff.flags[irq_src_pkg::ID_EXT0])
		else $error("either edge did not set external flag");
	a_pin1_rise_set: assert property (st_ff.ext_irq_enable[1] &&
		st_ff.edge_select_reg[3:2] == irq_src_pkg::EDGE_RISE &&
		st_ff.armed && ext_irq_pin[1] && !st_ff.pin_q[1]
		|=> st_ff.flags[irq_src_pkg::ID_EXT0 + 1])
		else $error("rising edge did not set second pin flag");
	a_pin_gated: assert property (!st_ff.ext_irq_enable[0] &&
		!st_ff.flags[irq_src_pkg::ID_EXT0]
		|=> !st_ff.flags[irq_src_pkg::ID_EXT0])
		else $error("pin without enable set its flag");
	a_edge1_off_quiet: assert property (st_ff.edge_select_reg[3:2] ==
		irq_src_pkg::EDGE_OFF && !st_ff.flags[irq_src_pkg::ID_EXT0 + 1]
		|=> !st_ff.flags[irq_src_pkg::ID_EXT0 + 1])
		else $error("disabled second pin set its flag");
	// pull-high only moves on a register write, never on interrupt events
	a_pull_kept: assert property (!st_ff.wr_pend |=>
		$stable(pin_pullup_en))
		else $error("pull-high select changed without write");
	a_ext_ack_clr: assert property (irq_ack && irq_req &&
		irq_vector == 4'(irq_src_pkg::ID_EXT0) && !ext_hit[0]
		|=> !st_ff.flags[irq_src_pkg::ID_EXT0] && !st_ff.gie)
		else $error("external service did not clear flag");
	a_cmp1_change_set: assert property (st_ff.armed &&
		(cmp_out[1] != st_ff.cmp_q[1])
		|=> st_ff.flags[irq_src_pkg::ID_CMP0 + 1])
		else $error("second comparator change did not set flag");
	a_cmp_ack_clr: assert property (irq_ack && irq_req &&
		irq_vector == 4'(irq_src_pkg::ID_CMP0) && !cmp_hit[0]
		|=> !st_ff.flags[irq_src_pkg::ID_CMP0] && !st_ff.gie)
		else $error("comparator service did not clear flag");
	a_vec_enabled: assert property (irq_req |->
		st_ff.flags[irq_vector] && en_vec[irq_vector])
		else $error("vector points at a source not pending");
	a_prio_order: assert property (irq_req |->
		(st_ff.flags & en_vec & ((N'(1) << irq_vector) - N'(1))) == '0)
		else $error("a higher priority source was skipped");
	a_group_gated: assert property (st_ff.src_en[3:0] == 4'h0 &&
		!st_ff.flags[irq_src_pkg::ID_MF0]
		|=> !st_ff.flags[irq_src_pkg::ID_MF0])
		else $error("group flag set with no source enabled");
	a_mf_ack_clr: assert property (irq_ack && irq_req &&
		irq_vector == 4'(irq_src_pkg::ID_MF0) && !mf_hit[0]
		|=> !st_ff.flags[irq_src_pkg::ID_MF0] && !st_ff.gie)
		else $error("group service did not clear flag");
	a_src_flag_set: assert property (|mf_src_req |=>
		(st_ff.src_flag & $past(mf_src_req)) == $past(mf_src_req))
		else $error("source request did not set source flag");
	a_conv_set: assert property (conv_done |=>
		st_ff.flags[irq_src_pkg::ID_CONV])
		else $error("conversion done did not set flag");
	a_tb1_ovf_set: assert property (tb_ovf[1] |=>
		st_ff.flags[irq_src_pkg::ID_TB1])
		else $error("time-base overflow did not set flag");
	a_tb_ack_clr: assert property (irq_ack && irq_req &&
		irq_vector == 4'(irq_src_pkg::ID_TB0) && !tb_ovf[0]
		|=> !st_ff.flags[irq_src_pkg::ID_TB0] && !st_ff.gie)
		else $error("time-base service did not clear flag");
	// a stopped divider must hold its count so periods restart cleanly
	a_tb_off_hold: assert property (!st_ff.wr_pend &&
		!st_ff.timebase_ctrl_reg[irq_src_pkg::TBC_ON]
		|=> $stable(st_ff.tb_cnt))
		else $error("time-base counter ran while off");
	a_full_no_req: assert property (stack_full && !irq_req |=>
		!irq_req)
		else $error("request rose while stack full");
	a_blocked_held: assert property (!st_ff.gie &&
		st_ff.flags[irq_src_pkg::ID_CONV] &&
		!(st_ff.wr_pend && st_ff.wr_addr == irq_src_pkg::OFS_FLAGS)
		|=> st_ff.flags[irq_src_pkg::ID_CONV])
		else $error("blocked request lost its flag");

	c_ext_serviced: cover property (irq_req && irq_ack && irq_vector == 4'h0);
	c_mf_serviced: cover property (irq_req && irq_ack &&
		irq_vector == 4'(irq_src_pkg::ID_MF0));
	c_stack_hold: cover property (stack_full && |st_ff.flags && st_ff.gie);
	c_tb0_flag: cover property (tb_ovf[0] ##1 st_ff.flags[irq_src_pkg::ID_TB0]);
	c_full_release: cover property (stack_full ##1 !stack_full ##1 irq_req);
endmodule

//--- rtl/irq_src_pkg.sv
// Overview of operation
// - chosen pin edge sets external flag
// - external vector needs global and pin enable
// - edge select: rising, falling or both
// - edge select setting can disable pin
// - pin counts only while its enable set
// - external service clears flag and global enable
// - pull-high selection stays while pin interrupts
// - comparator output change sets its flag
// - comparator vector needs enables, stack not full
// - comparator service clears flag and global enable
// - four multi-function interrupts from grouped sources
// - any enabled grouped source request sets group flag
// - multi-function vectors, clears flag, global enable
// - service leaves grouped source flags untouched
// - conversion done sets converter flag
// - converter vector gated; service clears flag, enable
// - time-base divider overflow sets its flag
// - time-base vector gated; service clears flag, enable
// - time-base ratio selected by control bits
// - full stack blocks every request
// - blocked requests still latch their flags
package irq_src_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EDGE = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_SRC_FLAG = 8'h0C;
	localparam logic [7:0] OFS_SRC_EN = 8'h10;
	localparam logic [7:0] OFS_TBC = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// control register field positions
	localparam int CTRL_GIE = 0;
	localparam int CTRL_EXT_EN = 1;
	localparam int CTRL_CMP_EN = 3;
	localparam int CTRL_MF_EN = 5;
	localparam int CTRL_CONV_EN = 9;
	localparam int CTRL_TB_EN = 10;
	localparam int CTRL_PULL = 12;
	// time-base control fields
	localparam int TBC_ON = 7;
	localparam int TBC_CK = 6;
	localparam int TBC_TB1 = 4;
	localparam int TBC_TB0 = 0;
	localparam logic [7:0] TBC_RESET = 8'h37;
	localparam int TB0_BASE_LOG2 = 8;
	localparam int TB1_BASE_LOG2 = 12;
	localparam int TB_CNT_W = 15;
	// edge select codes, two bits per pin
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// source index, lower index is higher priority
	localparam int NUM_SRC = 11;
	localparam int ID_EXT0 = 0;
	localparam int ID_CMP0 = 2;
	localparam int ID_MF0 = 4;
	localparam int ID_CONV = 8;
	localparam int ID_TB0 = 9;
	localparam int ID_TB1 = 10;
	localparam int MF_GROUPS = 4;
	localparam int MF_SRC_PER_GROUP = 4;
endpackage

//--- tb/irq_seq_model.sv
`timescale 1ns/1ns
module irq_seq_model
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bench control
	input wire logic full_cmd,
	input wire logic [7:0] ack_wait,
	// interrupt handshake
	input wire logic irq_req,
	input wire logic [3:0] irq_vector,
	output logic irq_ack,
	output logic stack_full,
	output logic [3:0] last_vec,
	output int acks
);
	logic [7:0] wait_ff;
	// no ack while full: a full stack has no room for a return address
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_ack <= 1'b0;
			stack_full <= 1'b0;
			last_vec <= 4'h0;
			acks <= 0;
			wait_ff <= 8'h00;
		end
		else
		begin
			stack_full <= full_cmd;
			irq_ack <= 1'b0;
			wait_ff <= 8'h00;
			if (irq_ack && irq_req)
			begin
				last_vec <= irq_vector;
				acks <= acks + 1;
			end
			else if (irq_req && !stack_full)
			begin
				wait_ff <= wait_ff + 8'h01;
				irq_ack <= (wait_ff >= ack_wait);
			end
		end
	end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
	logic hclk, hresetn, hwrite, conv_done, tb_tick, full_cmd;
	logic hreadyout, hresp, irq_req, irq_ack, stack_full;
	logic [1:0] htrans, ext_irq_pin, cmp_out, pin_pullup_en;
	logic [31:0] haddr, hwdata, hrdata, q, x;
	logic [15:0] mf_src_req;
	logic [3:0] irq_vector, last_vec;
	logic [7:0] ack_wait;
	int failures, tests_run, acks, cyc;

	mcu_interrupt_sources i_mcu_interrupt_sources
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_irq_pin(ext_irq_pin),
		.pin_pullup_en(pin_pullup_en), .cmp_out(cmp_out),
		.mf_src_req(mf_src_req), .conv_done(conv_done),
		.timebase_src_clock(tb_tick), .stack_full(stack_full),
		.irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector)
	);
	irq_seq_model i_irq_seq_model
	(
		.hclk(hclk), .hresetn(hresetn), .full_cmd(full_cmd),
		.ack_wait(ack_wait), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_ack(irq_ack), .stack_full(stack_full), .last_vec(last_vec),
		.acks(acks)
	);

	task automatic tally_and_finish();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// one single transfer; hready is the slave's own hreadyout
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string n);
		xfer(1'b0, a, 32'h0);
		chk(n, e, q & m);
	endtask

	task automatic rf(input logic [31:0] m, input logic [31:0] e,
		input string n);
		rd_chk(irq_src_pkg::OFS_FLAGS, m, e, n);
	endtask

	// acks are sampled on the falling edge to stay clear of the update
	task automatic serve(input logic [31:0] en, input logic [3:0] v);
		int n;
		n = acks;
		xfer(1'b1, irq_src_pkg::OFS_CTRL, en | 32'h1);
		for (int i = 0; i < 60 && acks == n; i++)
			@(negedge hclk);
		@(posedge hclk);
		chk("acks", 32'(n + 1), 32'(acks));
		chk("vector", {28'h0, v}, {28'h0, last_vec});
		rd_chk(irq_src_pkg::OFS_CTRL, 32'h1, 32'h0, "gie");
		rf(32'h1 << v, 32'h0, "flag");
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	initial
	begin
		hresetn = 1'b0;
		{hwrite, conv_done, tb_tick, full_cmd} = 4'h0;
		{htrans, ext_irq_pin, cmp_out} = 6'h00;
		{haddr, hwdata} = 64'h0;
		mf_src_req = 16'h0000;
		ack_wait = 8'h00;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(irq_src_pkg::OFS_TBC, 32'hFF, 32'h37, "tbc_reset");
		rd_chk(irq_src_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl_reset");
		rd_chk(8'hF0, 32'hFFFFFFFF, 32'h0, "unmapped");
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'b1, irq_src_pkg::OFS_EDGE, 32'(m));
			xfer(1'b1, irq_src_pkg::OFS_CTRL, 32'h3002);
			for (int e = 0; e < 2; e++)
			begin
				xfer(1'b1, irq_src_pkg::OFS_FLAGS, 32'h7FF);
				ext_irq_pin <= ~ext_irq_pin;
				repeat (3) @(posedge hclk);
				x = 32'((m >> e) & 1);
				rf(32'h1, x, "edge");
			end
		end
		chk("pullup", 32'h3, {30'h0, pin_pullup_en});
		xfer(1'b1, irq_src_pkg::OFS_CTRL, 32'h0);
		xfer(1'b1, irq_src_pkg::OFS_FLAGS, 32'h7FF);
		ext_irq_pin <= ~ext_irq_pin;
		repeat (3) @(posedge hclk);
		rf(32'h3, 32'h0, "pin_off");
		xfer(1'b1, irq_src_pkg::OFS_CTRL, 32'h2);
		ext_irq_pin <= ~ext_irq_pin;
		repeat (3) @(posedge hclk);
		chk("req_gated", 32'h0, {31'h0, irq_req});
		rf(32'h1, 32'h1, "held");
		serve(32'h2, 4'h0);
		cmp_out <= 2'h2;
		repeat (3) @(posedge hclk);
		serve(32'h10, 4'h3);
		full_cmd <= 1'b1;
		cmp_out <= 2'h3;
		conv_done <= 1'b1;
		@(posedge hclk);
		conv_done <= 1'b0;
		xfer(1'b1, irq_src_pkg::OFS_CTRL, 32'h209);
		repeat (6) @(posedge hclk);
		chk("req_full", 32'h0, {31'h0, irq_req});
		chk("hresp", 32'h0, {31'h0, hresp});
		rd_chk(irq_src_pkg::OFS_STATUS, 32'h30, 32'h20, "status");
		full_cmd <= 1'b0;
		serve(32'h208, 4'h2);
		serve(32'h208, 4'h8);
		for (int g = 0; g < 4; g++)
		begin
			x = 32'h2 << (4 * g);
			xfer(1'b1, irq_src_pkg::OFS_SRC_EN, x);
			mf_src_req <= x[15:0];
			@(posedge hclk);
			mf_src_req <= 16'h0000;
			serve(32'h20 << g, 4'(4 + g));
			rd_chk(irq_src_pkg::OFS_SRC_FLAG, x, x, "src");
			xfer(1'b1, irq_src_pkg::OFS_SRC_FLAG, x);
		end
		// slow acks from here; the time base ticks every cycle
		ack_wait <= 8'h06;
		tb_tick <= 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			xfer(1'b1, irq_src_pkg::OFS_TBC, 32'h80 | s);
			xfer(1'b1, irq_src_pkg::OFS_FLAGS, 32'h7FF);
			repeat ((256 << s) + 8) @(posedge hclk);
			rf(32'h200, 32'h200, "tb0");
		end
		xfer(1'b1, irq_src_pkg::OFS_TBC, 32'h80);
		xfer(1'b1, irq_src_pkg::OFS_FLAGS, 32'h7FF);
		repeat (4110) @(posedge hclk);
		rf(32'h400, 32'h400, "tb1");
		xfer(1'b1, irq_src_pkg::OFS_TBC, 32'h0);
		serve(32'h800, 4'hA);
		serve(32'h400, 4'h9);
		tally_and_finish();
	end
endmodule
